// [logic/cgc_pkg.sv]
package cgc_pkg;
	// Register byte addresses on the AXI4-Lite slave.
	localparam logic [3:0] SYSCLK_CTRL_OFS = 4'h0;
	localparam logic [3:0] LOWPWR_CTRL_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	// System clock control field positions.
	localparam int INHIBIT_BIT = 7;
	localparam int SWITCH_TIMING_BIT = 3;
	localparam int BUS_SEL_LSB = 0;
	localparam int BUS_SEL_W = 3;
	// Low-power control field positions.
	localparam int FACTOR_LSB = 0;
	localparam int FACTOR_W = 2;
	localparam int KEEP_ZERO_LSB = 2;
	localparam int KEEP_ZERO_W = 2;
	// Status register field positions.
	localparam int ST_FACTOR_LSB = 0;
	localparam int ST_PENDING_BIT = 2;
	localparam int ST_MODE_LSB = 4;
	// Reset values.
	localparam logic [7:0] SYSCLK_CTRL_RST = 8'h00;
	localparam logic [7:0] LOWPWR_CTRL_RST = 8'h00;
	// Bus clock select codes.
	localparam logic [2:0] BUS_FULL = 3'h0;
	localparam logic [2:0] BUS_DIV_MAX = 3'h5;
	// Factor codes.
	localparam logic [1:0] FACTOR_X1 = 2'h0;
	localparam logic [1:0] FACTOR_BAD = 2'h3;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Power modes, Gray coded along the usual path.
	typedef enum logic [2:0] {
		MODE_HIGH = 3'h0,
		MODE_MEDIUM = 3'h1,
		MODE_SLEEP = 3'h3,
		MODE_SW_STANDBY = 3'h2,
		MODE_HW_STANDBY = 3'h6
	} cgc_mode_t;
endpackage

// [logic/cgc_divider.sv]
`timescale 1ns/10ps
// Free-running divide chain; tap k toggles at clk/2^(k+1) as an enable.
module cgc_divider #(
	parameter int STAGES = 5
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Divided enables.
	output logic [STAGES-1:0] tick
);
	initial begin
		if (STAGES < 1 || STAGES > 16) begin
			$error("cgc_divider: STAGES out of range");
		end
	end
	logic [STAGES-1:0] count_r;
	logic [STAGES-1:0] count_nxt;
	assign count_nxt = count_r + {{(STAGES-1){1'b0}}, 1'b1};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= '0;
		end else if (clk_en) begin
			count_r <= count_nxt;
		end
	end
	// Tap k fires once every 2^(k+1) cycles.
	for (genvar k = 0; k < STAGES; k++) begin : g_tap
		assign tick[k] = clk_en && (&count_r[k:0]);
	end
endmodule

// [logic/cgc_clock_control.sv]
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/10ps
module cgc_clock_control #(
	parameter int DIV_STAGES = 5,
	parameter int WAKE_CYCLES = 16
) (
	// Clock, reset and enable.
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite write address and data.
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Power state.
	input wire logic sleep_req,
	input wire logic sw_standby_req,
	input wire logic hw_standby,
	input wire logic wake_req,
	// Clock outputs.
	output logic bus_clk_en,
	output logic [1:0] pll_factor,
	output logic clk_pin_o,
	output logic clk_pin_oe,
	output logic standby_active
);
	initial begin
		if (DIV_STAGES != 5 || WAKE_CYCLES < 1 || WAKE_CYCLES > 65535) begin
			$error("cgc_clock_control: unsupported parameters");
		end
	end

	logic [7:0] sysclk_ctrl_r;
	logic [7:0] lowpwr_ctrl_r;
	logic [1:0] factor_r;
	logic [15:0] wake_cnt_r;
	cgc_pkg::cgc_mode_t mode_r;
	cgc_pkg::cgc_mode_t mode_nxt;
	logic [31:0] rdata_nxt;
	logic aw_held_r, w_held_r;
	logic [3:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wstrb0_r;

	// Write channel: address and data accepted in either order.
	assign s_axi_awready = clk_en && !aw_held_r && !s_axi_bvalid;
	assign s_axi_wready = clk_en && !w_held_r && !s_axi_bvalid;
	wire aw_take = s_axi_awvalid && s_axi_awready;
	wire w_take = s_axi_wvalid && s_axi_wready;
	wire aw_have = aw_held_r || aw_take;
	wire w_have = w_held_r || w_take;
	wire [3:0] wa = aw_held_r ? awaddr_r : s_axi_awaddr;
	wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata;
	wire ws = w_held_r ? wstrb0_r : s_axi_wstrb[0];
	wire wr_do = clk_en && aw_have && w_have && !s_axi_bvalid;
	wire wr_sys = wr_do && ws && wa == cgc_pkg::SYSCLK_CTRL_OFS;
	wire wr_low = wr_do && ws && wa == cgc_pkg::LOWPWR_CTRL_OFS;
	wire wr_ok = wa == cgc_pkg::SYSCLK_CTRL_OFS
		|| wa == cgc_pkg::LOWPWR_CTRL_OFS || wa == cgc_pkg::STATUS_OFS;

	// Reserved bits six to four never store a one, so they read zero.
	wire [7:0] sys_wmask = 8'h8f;
	// Bits three and two are plain storage; software keeps them zero.
	wire [7:0] low_wmask = 8'h0f;
	wire [7:0] sys_nxt = wd[7:0] & sys_wmask;
	wire [7:0] low_nxt = wd[7:0] & low_wmask;

	wire inhibit = sysclk_ctrl_r[cgc_pkg::INHIBIT_BIT];
	wire immediate = sysclk_ctrl_r[cgc_pkg::SWITCH_TIMING_BIT];
	wire [2:0] bus_sel =
		sysclk_ctrl_r[cgc_pkg::BUS_SEL_LSB +: cgc_pkg::BUS_SEL_W];
	wire [1:0] req_factor =
		lowpwr_ctrl_r[cgc_pkg::FACTOR_LSB +: cgc_pkg::FACTOR_W];
	wire factor_pending = req_factor != factor_r;

	// Power mode sequencing.
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			cgc_pkg::MODE_HIGH, cgc_pkg::MODE_MEDIUM: begin
				if (sw_standby_req) begin
					mode_nxt = cgc_pkg::MODE_SW_STANDBY;
				end else if (sleep_req) begin
					mode_nxt = cgc_pkg::MODE_SLEEP;
				end else if (bus_sel == cgc_pkg::BUS_FULL) begin
					mode_nxt = cgc_pkg::MODE_HIGH;
				end else begin
					mode_nxt = cgc_pkg::MODE_MEDIUM;
				end
			end
			cgc_pkg::MODE_SLEEP: begin
				if (wake_req) begin
					mode_nxt = cgc_pkg::MODE_HIGH;
				end
			end
			cgc_pkg::MODE_SW_STANDBY: begin
				// The oscillator restarts only after the wait has run out.
				if (wake_cnt_r == 16'h0000 && wake_req) begin
					mode_nxt = cgc_pkg::MODE_HIGH;
				end
			end
			cgc_pkg::MODE_HW_STANDBY: begin
				mode_nxt = cgc_pkg::MODE_HIGH;
			end
			default: begin
				mode_nxt = cgc_pkg::MODE_HIGH;
			end
		endcase
		if (hw_standby) begin
			mode_nxt = cgc_pkg::MODE_HW_STANDBY;
		end
	end

	wire enter_standby = mode_r != cgc_pkg::MODE_SW_STANDBY
		&& mode_nxt == cgc_pkg::MODE_SW_STANDBY;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sysclk_ctrl_r <= cgc_pkg::SYSCLK_CTRL_RST;
			lowpwr_ctrl_r <= cgc_pkg::LOWPWR_CTRL_RST;
			factor_r <= cgc_pkg::FACTOR_X1;
			mode_r <= cgc_pkg::MODE_HIGH;
			wake_cnt_r <= 16'h0000;
		end else if (clk_en) begin
			mode_r <= mode_nxt;
			if (wr_sys) begin
				sysclk_ctrl_r <= sys_nxt;
			end
			if (wr_low) begin
				lowpwr_ctrl_r <= low_nxt;
			end
			// A prohibited factor code is never applied.
			if (req_factor != cgc_pkg::FACTOR_BAD) begin
				if (immediate || enter_standby) begin
					factor_r <= req_factor;
				end
			end
			if (enter_standby) begin
				wake_cnt_r <= 16'(WAKE_CYCLES);
			end else if (wake_cnt_r != 16'h0000) begin
				wake_cnt_r <= wake_cnt_r - 16'h0001;
			end
		end
	end

	// Write handshake bookkeeping.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			awaddr_r <= 4'h0;
			wdata_r <= 32'h0000_0000;
			wstrb0_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= cgc_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (wr_do) begin
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? cgc_pkg::RESP_OKAY : cgc_pkg::RESP_SLVERR;
			end else begin
				if (aw_take) begin
					aw_held_r <= 1'b1;
					awaddr_r <= s_axi_awaddr;
				end
				if (w_take) begin
					w_held_r <= 1'b1;
					wdata_r <= s_axi_wdata;
					wstrb0_r <= s_axi_wstrb[0];
				end
				if (s_axi_bready) begin
					s_axi_bvalid <= 1'b0;
				end
			end
		end
	end

	// Read channel.
	assign s_axi_arready = clk_en && !s_axi_rvalid;
	wire ar_take = s_axi_arvalid && s_axi_arready;
	wire [7:0] status = {1'b0, mode_r, 1'b0, factor_pending, factor_r};
	wire rd_sys = s_axi_araddr == cgc_pkg::SYSCLK_CTRL_OFS;
	wire rd_low = s_axi_araddr == cgc_pkg::LOWPWR_CTRL_OFS;
	wire rd_st = s_axi_araddr == cgc_pkg::STATUS_OFS;
	assign rdata_nxt = rd_sys ? {24'h000000, sysclk_ctrl_r}
		: rd_low ? {24'h000000, lowpwr_ctrl_r}
		: rd_st ? {24'h000000, status} : 32'h0000_0000;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= cgc_pkg::RESP_OKAY;
		end else if (clk_en) begin
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_nxt;
				s_axi_rresp <= (rd_sys || rd_low || rd_st)
					? cgc_pkg::RESP_OKAY : cgc_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Medium-speed divider and bus clock selection.
	logic [DIV_STAGES-1:0] tick;
	cgc_divider #(.STAGES(DIV_STAGES)) u_div (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.tick(tick)
	);
	// Codes above the largest divider leave full speed; software avoids them.
	wire bus_en_nxt = (bus_sel == cgc_pkg::BUS_FULL
		|| bus_sel > cgc_pkg::BUS_DIV_MAX) ? clk_en
		: tick[3'(bus_sel - 3'h1)];

	wire in_hw = mode_r == cgc_pkg::MODE_HW_STANDBY;
	wire in_sw = mode_r == cgc_pkg::MODE_SW_STANDBY;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clk_pin_o <= 1'b0;
			clk_pin_oe <= 1'b1;
		end else if (clk_en) begin
			clk_pin_oe <= !in_hw;
			// The pin shows a half-rate copy of the clock since it is registered.
			clk_pin_o <= (in_sw || inhibit) ? 1'b1 : !clk_pin_o;
		end
	end

	assign bus_clk_en = bus_en_nxt && !in_sw && !in_hw;
	assign pll_factor = factor_r;
	assign standby_active = in_sw || in_hw;

	// Assertions.
	a_reserved_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		sysclk_ctrl_r[6:4] == 3'h0) else $error("reserved bits set");
	a_immediate_apply: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && immediate && req_factor != cgc_pkg::FACTOR_BAD
		|=> factor_r == $past(req_factor)) else $error("no apply");
	sequence s_defer_hold;
		clk_en && !immediate && !enter_standby;
	endsequence
	a_deferred_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		s_defer_hold |=> $stable(factor_r)) else $error("early apply");
	a_pin_inhibit: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && (inhibit || in_sw) |=> clk_pin_o) else $error("pin low");
	a_pin_float: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && in_hw |=> !clk_pin_oe) else $error("pin driven");
	a_factor_legal: assert property (@(posedge aclk) disable iff (!aresetn)
		factor_r != cgc_pkg::FACTOR_BAD) else $error("bad factor");
	a_bus_full: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && bus_sel == cgc_pkg::BUS_FULL && !standby_active
		|-> bus_clk_en) else $error("bus clock gap");
	a_wake_wait: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && enter_standby |=> in_sw [*2]) else $error("short wait");
	a_reset_state: assert property (@(posedge aclk)
		!aresetn |=> factor_r == cgc_pkg::FACTOR_X1 && clk_pin_oe
		&& !immediate) else $error("reset state");
endmodule

// [dv/testbench.sv]
`timescale 1ns/10ps
module testbench;
	localparam logic [3:0] SC = cgc_pkg::SYSCLK_CTRL_OFS;
	localparam logic [3:0] LP = cgc_pkg::LOWPWR_CTRL_OFS;
	localparam int WAKE = 4;
	logic aclk, aresetn, clk_en;
	logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [1:0] s_axi_bresp, s_axi_rresp, pll_factor, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic sleep_req, sw_standby_req, hw_standby, wake_req;
	logic bus_clk_en, clk_pin_o, clk_pin_oe, standby_active;
	int bad_count, compares, ev, tg, hi, fac, nf, n;
	cgc_clock_control #(.DIV_STAGES(5), .WAKE_CYCLES(WAKE)) dut_u (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.sleep_req(sleep_req),
		.sw_standby_req(sw_standby_req),
		.hw_standby(hw_standby),
		.wake_req(wake_req),
		.bus_clk_en(bus_clk_en),
		.pll_factor(pll_factor),
		.clk_pin_o(clk_pin_o),
		.clk_pin_oe(clk_pin_oe),
		.standby_active(standby_active)
	);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task finish_test;
		$display("bad_count %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// The slave may take address and data on different edges.
	task wr(input logic [3:0] a, input logic [7:0] d);
		logic ta, tw, sa, sw;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		ta = 1'b0;
		tw = 1'b0;
		while (!(ta && tw)) begin
			@(negedge aclk);
			sa = s_axi_awvalid && s_axi_awready;
			sw = s_axi_wvalid && s_axi_wready;
			@(posedge aclk);
			if (sa) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (sw) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		sa = 1'b0;
		while (!sa) begin
			@(negedge aclk);
			sa = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge aclk);
		end
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [3:0] a);
		logic sa;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		sa = 1'b0;
		while (!sa) begin
			@(negedge aclk);
			sa = s_axi_arready;
			@(posedge aclk);
		end
		s_axi_arvalid <= 1'b0;
		sa = 1'b0;
		while (!sa) begin
			@(negedge aclk);
			sa = s_axi_rvalid;
			rdat = s_axi_rdata;
			resp = s_axi_rresp;
			@(posedge aclk);
		end
		s_axi_rready <= 1'b0;
	endtask
	// Counts bus enables, pin toggles and pin-high cycles over m cycles.
	task span(input int m);
		logic p;
		ev = 0;
		tg = 0;
		hi = 0;
		@(negedge aclk);
		p = clk_pin_o;
		repeat (m) begin
			@(negedge aclk);
			ev += int'(bus_clk_en === 1'b1);
			tg += int'(clk_pin_o !== p);
			hi += int'(clk_pin_o === 1'b1);
			p = clk_pin_o;
		end
	endtask
	initial begin
		#300000;
		bad_count++;
		finish_test;
	end
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, sleep_req, wake_req} = '0;
		{sw_standby_req, hw_standby} = '0;
		s_axi_wstrb = 4'hf;
		clk_en = 1'b1;
		aresetn = 1'b0;
		bad_count = 0;
		compares = 0;
		void'($urandom(43));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SC);
		chk(rdat, 32'h0);
		rd(LP);
		chk(rdat, 32'h0);
		chk({pll_factor, clk_pin_oe}, 3'h1);
		wr(SC, 8'hfd);
		chk(resp, cgc_pkg::RESP_OKAY);
		rd(SC);
		chk(rdat, 32'h8d);
		wr(LP, 8'h0c);
		rd(LP);
		chk(rdat, 32'h0c);
		wr(LP, 8'h00);
		wr(SC, 8'h08);
		for (int i = 0; i < 4; i++) begin
			fac = $urandom % 3;
			wr(LP, fac[7:0]);
			repeat (2) @(posedge aclk);
			chk(pll_factor, fac);
		end
		wr(LP, 8'h03);
		repeat (2) @(posedge aclk);
		chk(pll_factor, fac);
		for (int c = 0; c < 6; c++) begin
			wr(SC, 8'h08 | c[7:0]);
			span(64);
			chk(ev, 64 >> c);
		end
		wr(SC, 8'h88);
		span(8);
		chk(hi, 8);
		wr(SC, 8'h00);
		span(8);
		chk(tg, 8);
		// With the enable low nothing may move, pin and bus clock alike.
		@(posedge aclk);
		clk_en <= 1'b0;
		span(8);
		chk(ev, 0);
		chk(tg, 0);
		@(posedge aclk);
		clk_en <= 1'b1;
		@(posedge aclk);
		sleep_req <= 1'b1;
		rd(cgc_pkg::STATUS_OFS);
		chk(rdat[6:4], 3'h3);
		span(8);
		chk(tg, 8);
		@(posedge aclk);
		sleep_req <= 1'b0;
		wake_req <= 1'b1;
		repeat (3) @(posedge aclk);
		wake_req <= 1'b0;
		// Deferred switching: the new factor waits for standby entry.
		nf = (fac + 1) % 3;
		wr(LP, nf[7:0]);
		repeat (4) @(posedge aclk);
		chk(pll_factor, fac);
		@(posedge aclk);
		sw_standby_req <= 1'b1;
		for (n = 0; n < 20 && standby_active !== 1'b1; n++)
			@(negedge aclk);
		@(posedge aclk);
		chk(pll_factor, nf);
		span(4);
		chk(hi, 4);
		chk(ev, 0);
		@(posedge aclk);
		sw_standby_req <= 1'b0;
		wake_req <= 1'b1;
		for (n = 0; n < 50 && standby_active !== 1'b0; n++)
			@(negedge aclk);
		@(posedge aclk);
		wake_req <= 1'b0;
		// Wake is asked for at entry, so the stay shows the whole wait.
		@(posedge aclk);
		sw_standby_req <= 1'b1;
		wake_req <= 1'b1;
		for (n = 0; n < 20 && standby_active !== 1'b1; n++)
			@(negedge aclk);
		@(posedge aclk);
		sw_standby_req <= 1'b0;
		for (n = 0; n < 50 && standby_active !== 1'b0; n++)
			@(negedge aclk);
		@(posedge aclk);
		wake_req <= 1'b0;
		chk(n >= WAKE && n < 50, 1'b1);
		hw_standby <= 1'b1;
		repeat (3) @(posedge aclk);
		chk(clk_pin_oe, 1'b0);
		hw_standby <= 1'b0;
		rd(4'hc);
		chk(resp, cgc_pkg::RESP_SLVERR);
		chk(rdat, 32'h0);
		wr(4'hc, 8'h01);
		chk(resp, cgc_pkg::RESP_SLVERR);
		// A second reset in mid-run must clear what software set.
		wr(SC, 8'h8d);
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SC);
		chk(rdat, 32'h0);
		rd(LP);
		chk(rdat, 32'h0);
		chk({pll_factor, clk_pin_oe}, 3'h1);
		finish_test;
	end
endmodule
